// >>> src/wbt_pkg.sv
// Package for the wake bit timing recovery configuration block.
// Assumes one 125 MHz system clock and an 8-bit serial register port.
package wbt_pkg;
  // Register addresses on the serial port (7-bit address space).
  localparam logic [6:0] ADDR_OSC_CAL_LOW = 7'h3b;
  localparam logic [6:0] ADDR_CTRL_ONE = 7'h3c;
  localparam logic [6:0] ADDR_CTRL_TWO = 7'h3d;
  localparam logic [6:0] ADDR_UPPER_LIMIT = 7'h3e;
  localparam logic [6:0] ADDR_LOWER_LIMIT = 7'h3f;
  // Field positions.
  localparam int EN_BIT = 0;
  localparam int FILT_LO = 2;
  localparam int FILT_HI = 3;
  localparam int CLKSEL_LO = 0;
  localparam int CLKSEL_HI = 1;
  // Reset values.
  localparam logic [7:0] OSC_CAL_LOW_RST = 8'h00;
  localparam logic [1:0] FILT_RST = 2'h1;
  localparam logic [1:0] CLKSEL_RST = 2'h0;
  localparam logic [7:0] UPPER_LIMIT_RST = 8'ha8;
  localparam logic [7:0] LOWER_LIMIT_RST = 8'h98;
  // Recovery clock rates selected by the clock select field, in MHz.
  localparam int RATE_SEL0_MHZ = 80;
  localparam int RATE_SEL1_MHZ = 40;
  localparam int RATE_SEL2_MHZ = 20;
  localparam int RATE_SEL3_MHZ = 10;
  // Filter time constants as shift amounts: 8, 16 and 32.
  localparam logic [2:0] TC8_SHIFT = 3'h3;
  localparam logic [2:0] TC16_SHIFT = 3'h4;
  localparam logic [2:0] TC32_SHIFT = 3'h5;
  // Edge spacing bands for the adaptive filter, in bits.
  localparam logic [3:0] SPACE_FAST_MIN = 4'h2;
  localparam logic [3:0] SPACE_FAST_MAX = 4'h3;
  localparam logic [3:0] SPACE_MID_MAX = 4'h8;
  localparam logic [3:0] SPACE_SLOW_MAX = 4'ha;
  // Filter field encodings.
  localparam logic [1:0] FILT_TC8 = 2'h0;
  localparam logic [1:0] FILT_TC16 = 2'h1;
  localparam logic [1:0] FILT_TC32 = 2'h2;
  localparam logic [1:0] FILT_ADAPT = 2'h3;
  // Serial frame length and position of the mode bit.
  localparam logic [4:0] SPI_HALF_BITS = 5'h08;
  localparam logic [4:0] SPI_FRAME_BITS = 5'h10;

  // Configuration held in the register file.
  typedef struct packed {
    logic enable;
    logic [1:0] filt_sel;
    logic [1:0] clk_sel;
    logic [7:0] upper;
    logic [7:0] lower;
    logic [7:0] cal_low;
  } wbt_cfg_type;

  // Serial port state, including the synchronisers on its pins.
  typedef struct packed {
    logic [1:0] sck_sync;
    logic [1:0] cs_sync;
    logic [1:0] mosi_sync;
    logic sck_prev;
    logic cs_prev;
    logic [4:0] count;
    logic [15:0] shift;
    logic [7:0] tx;
    logic miso;
  } wbt_spi_type;

  // Bit timing recovery state.
  typedef struct packed {
    logic [1:0] rx_sync;
    logic rx_prev;
    logic [2:0] div;
    logic [7:0] phase;
    logic [3:0] nbits;
    logic [7:0] bit_time;
    logic strobe;
  } wbt_cdr_type;

  // Whole state of the block.
  typedef struct packed {
    wbt_cfg_type cfg;
    wbt_spi_type spi;
    wbt_cdr_type cdr;
  } wbt_state_type;
endpackage

// >>> src/wbt_recovery_cfg.sv
// Register file, serial port and bit timing recovery of the wake detector.
// Assumes sck, cs_n, mosi and rx_pin come from outside the clock domain
// and osc_tick and osc_cal_low_in come from logic on the same clock.
//
// How it works
// (RQ1) Calibration low byte is read only and resets to zero.
// (RQ2) Control one bit 0 enables recovery; it resets to zero.
// (RQ3) Filter field picks time constant 8, 16 or 32; resets to 16.
// (RQ4) Field value 11 adapts the constant to falling edge spacing.
// (RQ5) Clock select divides the recovery clock: 80, 40, 20, 10 MHz.
// (RQ6) Upper limit register clamps bit time from above; resets to a8.
// (RQ7) Lower limit register clamps bit time from below; resets to 98.
// (RQ8) Host programs bit time and limits to suit the baud ratio.
// (RQ9) Host avoids clock choices that overflow the bit time counter.
// (RQ10) Host avoids slow clocks where timing precision is too coarse.
// (RQ11) Reserved bits of both control registers always read zero.
// (RQ12) Host need not retrim the oscillator since recovery compensates.
// (RQ13) Bit time is counted in recovery cycles, filtered, then clamped.
module wbt_recovery_cfg #(
  parameter int BT_WIDTH = 8
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic sck,
  input wire logic cs_n,
  input wire logic mosi,
  output logic miso,
  output logic miso_oe,
  input wire logic rx_pin,
  input wire logic osc_tick,
  input wire logic [7:0] osc_cal_low_in,
  input wire logic [7:0] bit_time_register,
  output logic [7:0] recovered_bit_time,
  output logic bit_strobe,
  output logic recovery_enable
);
  wbt_pkg::wbt_state_type state_r;
  wbt_pkg::wbt_state_type state_nxt;
  logic sck_rise;
  logic sck_fall;
  logic cs_rise;
  logic cs_fall;
  logic [7:0] rd_data;
  logic [6:0] rd_addr;
  logic [6:0] wr_addr;
  logic [7:0] wr_data;
  logic wr_fire;
  logic rx_fall;
  logic rc_tick;
  logic [2:0] tc_shift;
  logic [8:0] err;
  logic [8:0] step;
  logic [8:0] sum;
  logic [7:0] half;

  // The datapath is sized for the documented 8-bit bit time registers,
  // so any other width is refused while the design is elaborated.
  if (BT_WIDTH != 8) begin
    $error("BT_WIDTH must be 8");
  end

  // Edges seen on the second synchroniser stage only.
  assign sck_rise = state_r.spi.sck_sync[1] & ~state_r.spi.sck_prev;
  assign sck_fall = ~state_r.spi.sck_sync[1] & state_r.spi.sck_prev;
  assign cs_rise = state_r.spi.cs_sync[1] & ~state_r.spi.cs_prev;
  assign cs_fall = ~state_r.spi.cs_sync[1] & state_r.spi.cs_prev;
  assign rx_fall = ~state_r.cdr.rx_sync[1] & state_r.cdr.rx_prev;

  // Address after the first byte; write commits at deselect of 16 bits.
  assign rd_addr = state_r.spi.shift[14:8];
  assign wr_addr = state_r.spi.shift[6:0];
  assign wr_data = state_r.spi.shift[15:8];
  assign wr_fire = cs_rise && state_r.spi.shift[7]
                   && state_r.spi.count == wbt_pkg::SPI_FRAME_BITS;

  // Read mux; reserved bits and unmapped addresses read as zero.
  always_comb begin
    rd_data = 8'h00;
    if (rd_addr == wbt_pkg::ADDR_OSC_CAL_LOW) begin
      rd_data = state_r.cfg.cal_low; // see (RQ1)
    end else if (rd_addr == wbt_pkg::ADDR_CTRL_ONE) begin
      rd_data[wbt_pkg::EN_BIT] = state_r.cfg.enable; // see (RQ11)
      rd_data[wbt_pkg::FILT_HI:wbt_pkg::FILT_LO] = state_r.cfg.filt_sel;
    end else if (rd_addr == wbt_pkg::ADDR_CTRL_TWO) begin
      rd_data[wbt_pkg::CLKSEL_HI:wbt_pkg::CLKSEL_LO] =
        state_r.cfg.clk_sel; // see (RQ11)
    end else if (rd_addr == wbt_pkg::ADDR_UPPER_LIMIT) begin
      rd_data = state_r.cfg.upper;
    end else if (rd_addr == wbt_pkg::ADDR_LOWER_LIMIT) begin
      rd_data = state_r.cfg.lower;
    end
  end

  // Recovery clock: the oscillator tick divided by 1, 2, 4 or 8.
  always_comb begin
    case (state_r.cfg.clk_sel) // see (RQ5)
      2'h0: rc_tick = osc_tick;
      2'h1: rc_tick = osc_tick & state_r.cdr.div[0];
      2'h2: rc_tick = osc_tick & (&state_r.cdr.div[1:0]);
      default: rc_tick = osc_tick & (&state_r.cdr.div);
    endcase
  end

  // Filter time constant, fixed or chosen from the edge spacing.
  always_comb begin
    case (state_r.cfg.filt_sel) // see (RQ3)
      wbt_pkg::FILT_TC8: tc_shift = wbt_pkg::TC8_SHIFT;
      wbt_pkg::FILT_TC16: tc_shift = wbt_pkg::TC16_SHIFT;
      wbt_pkg::FILT_TC32: tc_shift = wbt_pkg::TC32_SHIFT;
      default: begin
        // Spacings outside the bands fall back to the middle constant.
        if (state_r.cdr.nbits >= wbt_pkg::SPACE_FAST_MIN
            && state_r.cdr.nbits <= wbt_pkg::SPACE_FAST_MAX) begin
          tc_shift = wbt_pkg::TC32_SHIFT; // see (RQ4)
        end else if (state_r.cdr.nbits > wbt_pkg::SPACE_MID_MAX
                     && state_r.cdr.nbits <= wbt_pkg::SPACE_SLOW_MAX) begin
          tc_shift = wbt_pkg::TC8_SHIFT; // see (RQ4)
        end else begin
          tc_shift = wbt_pkg::TC16_SHIFT; // see (RQ4)
        end
      end
    endcase
  end

  // Phase error at a falling edge: late edges give a positive error.
  always_comb begin
    half = {1'b0, state_r.cdr.bit_time[7:1]};
    if (state_r.cdr.phase < half) begin
      err = {1'b0, state_r.cdr.phase};
    end else begin
      err = {1'b0, state_r.cdr.phase} - {1'b0, state_r.cdr.bit_time};
    end
    step = $signed(err) >>> tc_shift;
    sum = {1'b0, state_r.cdr.bit_time} + step;
  end

  // Next state of the whole block.
  always_comb begin
    state_nxt = state_r;
    // Two flip-flop synchronisers on every pin input.
    state_nxt.spi.sck_sync = {state_r.spi.sck_sync[0], sck};
    state_nxt.spi.cs_sync = {state_r.spi.cs_sync[0], cs_n};
    state_nxt.spi.mosi_sync = {state_r.spi.mosi_sync[0], mosi};
    state_nxt.cdr.rx_sync = {state_r.cdr.rx_sync[0], rx_pin};
    state_nxt.spi.sck_prev = state_r.spi.sck_sync[1];
    state_nxt.spi.cs_prev = state_r.spi.cs_sync[1];
    state_nxt.cdr.rx_prev = state_r.cdr.rx_sync[1];
    state_nxt.cfg.cal_low = osc_cal_low_in; // see (RQ1)
    state_nxt.cdr.strobe = 1'b0;

    // Serial shifter, LSB first, sampled on the rising clock edge.
    if (cs_fall) begin
      state_nxt.spi.count = 5'h00;
      state_nxt.spi.tx = 8'h00;
      state_nxt.spi.miso = 1'b0;
    end else if (!state_r.spi.cs_sync[1]) begin
      if (sck_rise && state_r.spi.count != wbt_pkg::SPI_FRAME_BITS) begin
        state_nxt.spi.shift = {state_r.spi.mosi_sync[1],
                               state_r.spi.shift[15:1]};
        state_nxt.spi.count = state_r.spi.count + 5'h01;
      end
      // Read data is latched once the address byte is complete.
      if (sck_fall) begin
        if (state_r.spi.count == wbt_pkg::SPI_HALF_BITS) begin
          state_nxt.spi.miso = rd_data[0];
          state_nxt.spi.tx = {1'b0, rd_data[7:1]};
        end else begin
          state_nxt.spi.miso = state_r.spi.tx[0];
          state_nxt.spi.tx = {1'b0, state_r.spi.tx[7:1]};
        end
      end
    end

    // Register writes; a frame shorter than 16 bits is dropped.
    if (wr_fire) begin
      if (wr_addr == wbt_pkg::ADDR_CTRL_ONE) begin
        state_nxt.cfg.enable = wr_data[wbt_pkg::EN_BIT]; // see (RQ2)
        state_nxt.cfg.filt_sel =
          wr_data[wbt_pkg::FILT_HI:wbt_pkg::FILT_LO]; // see (RQ3)
      end else if (wr_addr == wbt_pkg::ADDR_CTRL_TWO) begin
        state_nxt.cfg.clk_sel =
          wr_data[wbt_pkg::CLKSEL_HI:wbt_pkg::CLKSEL_LO]; // see (RQ5)
      end else if (wr_addr == wbt_pkg::ADDR_UPPER_LIMIT) begin
        state_nxt.cfg.upper = wr_data; // see (RQ6)
      end else if (wr_addr == wbt_pkg::ADDR_LOWER_LIMIT) begin
        state_nxt.cfg.lower = wr_data; // see (RQ7)
      end
    end

    // Recovery: count recovery cycles per bit and track the bit time.
    if (osc_tick) begin
      state_nxt.cdr.div = state_r.cdr.div + 3'h1;
    end
    if (!state_r.cfg.enable) begin
      // Disabled: follow the nominal value so enabling starts clean.
      state_nxt.cdr.bit_time = bit_time_register; // see (RQ2)
      state_nxt.cdr.phase = 8'h00;
      state_nxt.cdr.nbits = 4'h0;
    end else if (rx_fall) begin
      // Filtered sample, then clamped to the programmed window.
      if (state_r.cdr.nbits != 4'h0
          && state_r.cdr.nbits <= wbt_pkg::SPACE_SLOW_MAX) begin
        if (sum[8] && step[8]) begin
          state_nxt.cdr.bit_time = state_r.cfg.lower; // see (RQ13)
        end else if (sum[8] || sum[7:0] > state_r.cfg.upper) begin
          state_nxt.cdr.bit_time = state_r.cfg.upper; // see (RQ6)
        end else if (sum[7:0] < state_r.cfg.lower) begin
          state_nxt.cdr.bit_time = state_r.cfg.lower; // see (RQ7)
        end else begin
          state_nxt.cdr.bit_time = sum[7:0]; // see (RQ13)
        end
      end
      state_nxt.cdr.phase = 8'h00;
      state_nxt.cdr.nbits = 4'h1;
    end else if (rc_tick) begin
      if (state_r.cdr.phase + 8'h01 >= state_r.cdr.bit_time) begin
        state_nxt.cdr.phase = 8'h00;
        state_nxt.cdr.strobe = 1'b1;
        // Saturate so a long idle bus does not wrap into a band.
        if (state_r.cdr.nbits != 4'hf) begin
          state_nxt.cdr.nbits = state_r.cdr.nbits + 4'h1;
        end
      end else begin
        state_nxt.cdr.phase = state_r.cdr.phase + 8'h01; // see (RQ13)
      end
    end
  end

  // One register stage for the whole state.
  always_ff @(posedge clk) begin
    if (reset) begin
      state_r <= '0;
      state_r.spi.sck_sync <= 2'h0;
      state_r.spi.cs_sync <= 2'h3;
      state_r.spi.cs_prev <= 1'b1;
      state_r.cdr.rx_sync <= 2'h3;
      state_r.cdr.rx_prev <= 1'b1;
      state_r.cfg.cal_low <= wbt_pkg::OSC_CAL_LOW_RST; // see (RQ1)
      state_r.cfg.filt_sel <= wbt_pkg::FILT_RST; // see (RQ3)
      state_r.cfg.clk_sel <= wbt_pkg::CLKSEL_RST; // see (RQ5)
      state_r.cfg.upper <= wbt_pkg::UPPER_LIMIT_RST; // see (RQ6)
      state_r.cfg.lower <= wbt_pkg::LOWER_LIMIT_RST; // see (RQ7)
    end else begin
      state_r <= state_nxt;
    end
  end

  // Outputs straight from the state register.
  assign miso = state_r.spi.miso;
  assign miso_oe = ~state_r.spi.cs_sync[1];
  assign recovered_bit_time = state_r.cdr.bit_time;
  assign bit_strobe = state_r.cdr.strobe;
  assign recovery_enable = state_r.cfg.enable;
endmodule

// >>> tb/wbt_recovery_cfg_props.sv
// Assertions for the wake bit timing recovery configuration block.
// Assumes it is bound to wbt_recovery_cfg and sees only its ports.
module wbt_recovery_cfg_props (
  input wire logic clk,
  input wire logic reset,
  input wire logic cs_n,
  input wire logic rx_pin,
  input wire logic miso_oe,
  input wire logic [7:0] bit_time_register,
  input wire logic [7:0] recovered_bit_time,
  input wire logic bit_strobe,
  input wire logic recovery_enable
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  // Outputs come out of reset quiet; the pin sync delays are covered.
  chk_reset_quiet_out: assert property ($past(reset) && !reset |->
    !recovery_enable && !bit_strobe && !miso_oe) else $error("not quiet");
  chk_port_oe_idle: assert property (cs_n [*4] |-> !miso_oe)
    else $error("miso driven while deselected");
  chk_port_oe_drive: assert property (!cs_n [*5] |-> miso_oe)
    else $error("miso not driven while selected");
  chk_strobe_one_cycle: assert property (bit_strobe |=> !bit_strobe)
    else $error("bit strobe longer than one cycle");
  chk_strobe_when_off: assert property (!recovery_enable &&
    $past(!recovery_enable) |-> !bit_strobe) else $error("strobe while off");
  // While disabled the nominal value passes straight through.
  chk_follow_nominal_bt: assert property (!recovery_enable &&
    $past(!recovery_enable) && $stable(bit_time_register) |=>
    recovered_bit_time == $past(bit_time_register))
    else $error("bit time does not follow nominal");
  // Without a falling edge on the receive pin no update may happen.
  chk_hold_quiet_line: assert property (recovery_enable &&
    $past(recovery_enable) && $past(recovery_enable, 2) && rx_pin &&
    $past(rx_pin) && $past(rx_pin, 2) && $past(rx_pin, 3) &&
    $past(rx_pin, 4) && $past(rx_pin, 5) |-> $stable(recovered_bit_time))
    else $error("bit time changed on a quiet line");
  chk_enable_after_frame: assert property ($changed(recovery_enable)
    |-> cs_n) else $error("enable changed inside a frame");
endmodule
bind wbt_recovery_cfg wbt_recovery_cfg_props i_props (.clk(clk),
  .reset(reset), .cs_n(cs_n), .rx_pin(rx_pin), .miso_oe(miso_oe),
  .bit_time_register(bit_time_register),
  .recovered_bit_time(recovered_bit_time), .bit_strobe(bit_strobe),
  .recovery_enable(recovery_enable));

// >>> tb/wbt_can_sender.sv
// Model of a CAN node sending wake frame edges on the receive line.
// Assumes the bench gives the falling edge spacing in clock cycles.
module wbt_can_sender (
  input wire logic clk,
  input wire logic run,
  input wire logic [15:0] spacing,
  output logic rx_pin
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] count = 16'h0000;
  initial rx_pin = 1'b1;
  // The line idles recessive; each period opens with a dominant quarter,
  // so every period gives exactly one falling edge.
  always @(posedge clk) begin
    #1;
    if (!run || count >= spacing - 16'h0001) count = 16'h0000;
    else count = count + 16'h0001;
    rx_pin = !run || (count >= (spacing >> 2));
  end
endmodule

// >>> tb/wbt_recovery_cfg_bench.sv
// Self-checking bench for the wake bit timing recovery configuration block.
// Assumes the checker is bound in and a CAN sender drives the receive pin.
module wbt_recovery_cfg_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic sck = 1'b0;
  logic cs_n = 1'b1;
  logic mosi = 1'b0;
  logic [7:0] cal_in = 8'h00;
  logic [7:0] nominal = 8'ha0;
  logic run = 1'b0;
  logic [15:0] spacing = 16'h0140;
  logic miso, miso_oe, rx_pin, bit_strobe, recovery_enable;
  logic [7:0] bt_out, rd, lim;
  int num_errors = 0;
  int comparisons = 0;
  int cycles = 0;
  int strobes = 0;
`define CHECK(got, exp) begin comparisons++; if ((got) !== (exp)) begin \
  num_errors++; $display("unexpected at %0t got %h expected %h", \
  $time, got, exp); end end

  always #4 clk = ~clk;
  wbt_recovery_cfg i_dut (.clk(clk), .reset(reset), .sck(sck),
    .cs_n(cs_n), .mosi(mosi), .miso(miso), .miso_oe(miso_oe),
    .rx_pin(rx_pin), .osc_tick(1'b1), .osc_cal_low_in(cal_in),
    .bit_time_register(nominal), .recovered_bit_time(bt_out),
    .bit_strobe(bit_strobe), .recovery_enable(recovery_enable));
  wbt_can_sender i_sender (.clk(clk), .run(run), .spacing(spacing),
    .rx_pin(rx_pin));

  // Count strobes and cut a hung run short.
  always @(posedge clk) begin
    cycles++;
    if (bit_strobe === 1'b1) strobes++;
    if (cycles == 50000) begin
      num_errors++;
      stop_test();
    end
  end

  task stop_test;
    $display("comparisons %0d mismatches %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  task step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // One 16-bit frame, LSB first; sck phases are wide enough for the sync.
  task xfer(input logic [6:0] a, input logic wr, input logic [7:0] d);
    logic [15:0] f;
    f = {d, wr, a};
    cs_n = 1'b0;
    step(5);
    for (int i = 0; i < 16; i++) begin
      mosi = f[i];
      step(5);
      if (i >= 8) rd[i-8] = miso;
      sck = 1'b1;
      step(5);
      sck = 1'b0;
    end
    step(5);
    cs_n = 1'b1;
    step(8);
  endtask

  task rd_chk(input logic [6:0] a, input logic [7:0] e);
    xfer(a, 1'b0, 8'h00);
    `CHECK(rd, e)
  endtask

  task t_reset_values;
    rd_chk(wbt_pkg::ADDR_OSC_CAL_LOW, 8'h00);
    rd_chk(wbt_pkg::ADDR_CTRL_ONE, 8'h04);
    rd_chk(wbt_pkg::ADDR_CTRL_TWO, 8'h00);
    rd_chk(wbt_pkg::ADDR_UPPER_LIMIT, 8'ha8);
    rd_chk(wbt_pkg::ADDR_LOWER_LIMIT, 8'h98);
    rd_chk(7'h40, 8'h00);
    `CHECK(recovery_enable, 1'b0)
    $display("test reset_values done");
  endtask

  // Reserved bits read zero, the calibration byte ignores writes.
  task t_registers;
    xfer(wbt_pkg::ADDR_CTRL_ONE, 1'b1, 8'hff);
    rd_chk(wbt_pkg::ADDR_CTRL_ONE, 8'h0d);
    `CHECK(recovery_enable, 1'b1)
    for (int s = 0; s < 4; s++) begin
      xfer(wbt_pkg::ADDR_CTRL_TWO, 1'b1, {6'h3f, s[1:0]});
      rd_chk(wbt_pkg::ADDR_CTRL_TWO, {6'h00, s[1:0]});
    end
    xfer(wbt_pkg::ADDR_CTRL_TWO, 1'b1, 8'h00);
    cal_in = 8'h5a;
    xfer(wbt_pkg::ADDR_OSC_CAL_LOW, 1'b1, 8'hff);
    rd_chk(wbt_pkg::ADDR_OSC_CAL_LOW, 8'h5a);
    xfer(wbt_pkg::ADDR_UPPER_LIMIT, 1'b1, 8'h55);
    rd_chk(wbt_pkg::ADDR_UPPER_LIMIT, 8'h55);
    xfer(wbt_pkg::ADDR_CTRL_ONE, 1'b1, 8'h00);
    step(3);
    `CHECK(bt_out, nominal)
    $display("test registers done");
  endtask

  // Equal limits pin the result, so every filter mode must land on them.
  task t_clamp;
    for (int f = 0; f < 4; f++) begin
      lim = 8'h90 + 8'(f * 8);
      xfer(wbt_pkg::ADDR_UPPER_LIMIT, 1'b1, lim);
      xfer(wbt_pkg::ADDR_LOWER_LIMIT, 1'b1, lim);
      xfer(wbt_pkg::ADDR_CTRL_ONE, 1'b1, {4'h0, f[1:0], 2'h1});
      spacing = {7'h00, lim, 1'b0};
      strobes = 0;
      run = 1'b1;
      step(8 * int'(lim));
      `CHECK(bt_out, lim)
      `CHECK((strobes != 0), 1'b1)
      run = 1'b0;
    end
    xfer(wbt_pkg::ADDR_CTRL_ONE, 1'b1, 8'h04);
    xfer(wbt_pkg::ADDR_UPPER_LIMIT, 1'b1, 8'ha8);
    xfer(wbt_pkg::ADDR_LOWER_LIMIT, 1'b1, 8'h98);
    $display("test clamp done");
  endtask

  // Idle line: strobes come once per bit time of recovery clock cycles.
  // The window leaves about 100 cycles of slack for the start-up phase.
  task t_clock_select;
    int period;
    for (int s = 0; s < 4; s++) begin
      case (s)
        0: period = 1;
        1: period = wbt_pkg::RATE_SEL0_MHZ / wbt_pkg::RATE_SEL1_MHZ;
        2: period = wbt_pkg::RATE_SEL0_MHZ / wbt_pkg::RATE_SEL2_MHZ;
        default: period = wbt_pkg::RATE_SEL0_MHZ / wbt_pkg::RATE_SEL3_MHZ;
      endcase
      period = period * int'(nominal);
      xfer(wbt_pkg::ADDR_CTRL_TWO, 1'b1, {6'h00, s[1:0]});
      xfer(wbt_pkg::ADDR_CTRL_ONE, 1'b1, 8'h05);
      strobes = 0;
      step(1700);
      `CHECK(strobes, 1600 / period)
      xfer(wbt_pkg::ADDR_CTRL_ONE, 1'b1, 8'h04);
    end
    xfer(wbt_pkg::ADDR_CTRL_TWO, 1'b1, 8'h00);
    $display("test clock_select done");
  endtask

  initial begin
    step(2);
    reset = 1'b0;
    step(3);
    t_reset_values();
    t_registers();
    t_clamp();
    t_clock_select();
    stop_test();
  end
endmodule
